// ### ciw_pkg.sv
`timescale 1ns/1ns
`default_nettype none
package ciw_pkg;
    // Register byte addresses
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] CFG_ADDR = 8'h04;
    localparam logic [7:0] RXFLG_ADDR = 8'h08;
    localparam logic [7:0] RXIEN_ADDR = 8'h0C;
    localparam logic [7:0] TXFLG_ADDR = 8'h10;
    localparam logic [7:0] TXIEN_ADDR = 8'h14;
    localparam logic [7:0] STAT_ADDR = 8'h18;
    // Control register fields
    localparam int CTRL_INIT_REQUEST_BIT = 0;
    localparam int CTRL_SLEEPRQ_BIT = 1;
    localparam int CTRL_WAKEEN_BIT = 2;
    localparam int CTRL_HOLD_BIT = 3;
    // Configuration register fields
    localparam int CFG_MODEN_BIT = 0;
    localparam int CFG_FILT_BIT = 1;
    localparam int CFG_MANREC_BIT = 2;
    // Receiver flag/enable fields
    localparam int RX_FULL_BIT = 0;
    localparam int RX_OVR_BIT = 1;
    localparam int RX_TST_LSB = 2;
    localparam int RX_RST_LSB = 4;
    localparam int RX_CSC_BIT = 6;
    localparam int RX_WAKE_BIT = 7;
    // Status register fields
    localparam int ST_INIT_ACKNOWLEDGE_BIT = 0;
    localparam int ST_SLEEPAK_BIT = 1;
    localparam int ST_BUSOFF_BIT = 2;
    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [2:0] TXE_RESET = 3'h7;
    // Timing counts
    localparam logic [3:0] RECESSIVE_RUN = 4'hB;
    localparam logic [7:0] RECOVERY_RUNS = 8'h80;
    localparam logic [3:0] WAKE_FILTER_LEN = 4'h4;
    localparam logic [2:0] INIT_SYNC_CYCLES = 3'h5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_WARN = 2'b01,
        ST_PASSIVE = 2'b10,
        ST_BUSOFF = 2'b11
    } ciw_bstate_t;
    // Events from the protocol engine
    typedef struct packed {
        logic rxDone;
        logic fifoNext;
        logic overrun;
        logic [2:0] txDone;
        logic txBusy;
        logic rxBusy;
        logic bitTick;
    } ciw_evt_t;
    // Interrupt request lines
    typedef struct packed {
        logic wake;
        logic err;
        logic rx;
        logic tx;
    } ciw_irq_t;
endpackage
`default_nettype wire

// ### ciw_core.sv
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module ciw_core (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic can_receive_line,
    input wire ciw_pkg::ciw_evt_t evt,
    input wire logic [1:0] tx_state_in,
    input wire logic [1:0] rx_state_in,
    input wire logic power_down,
    output ciw_pkg::ciw_irq_t irq,
    output logic [2:0] tx_buffer_empty_flags,
    output logic can_active
);
    ////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl_r, cfg_r;
    logic [7:0] rxFlag_r, rxIen_r;
    logic [2:0] txFlag_r, txIen_r;
    logic [1:0] tx_state_field_r, rx_state_field_r;
    logic sleepAck_r, initAck_r, busOff_r, resync_r, pdSleep_r;
    logic [2:0] initCnt_r;
    logic [3:0] recCnt_r, filtCnt_r;
    logic [7:0] runCnt_r;
    logic awHeld_r, wHeld_r;
    logic [7:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;

    wire logic init_request = ctrl_r[ciw_pkg::CTRL_INIT_REQUEST_BIT];
    wire logic sleepRq = ctrl_r[ciw_pkg::CTRL_SLEEPRQ_BIT];
    wire logic wake_on_activity_enable = ctrl_r[ciw_pkg::CTRL_WAKEEN_BIT];
    wire logic busoff_hold_bit = ctrl_r[ciw_pkg::CTRL_HOLD_BIT];
    wire logic module_enable_bit = cfg_r[ciw_pkg::CFG_MODEN_BIT];
    wire logic wake_filter_select = cfg_r[ciw_pkg::CFG_FILT_BIT];
    wire logic manual_recovery_bit = cfg_r[ciw_pkg::CFG_MANREC_BIT];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    wire logic doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
    wire logic [31:0] wMask = wData_r & {{8{wStrb_r[3]}}, {8{wStrb_r[2]}},
                                         {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
    wire logic wrCtrl = doWrite && awAddr_r == ciw_pkg::CTRL_ADDR;
    wire logic wrCfg = doWrite && awAddr_r == ciw_pkg::CFG_ADDR;
    wire logic wrRxF = doWrite && awAddr_r == ciw_pkg::RXFLG_ADDR;
    wire logic wrRxE = doWrite && awAddr_r == ciw_pkg::RXIEN_ADDR;
    wire logic wrTxF = doWrite && awAddr_r == ciw_pkg::TXFLG_ADDR;
    wire logic wrTxE = doWrite && awAddr_r == ciw_pkg::TXIEN_ADDR;
    wire logic wrOk = wrCtrl | wrCfg | wrRxF | wrRxE | wrTxF | wrTxE
                      | (awAddr_r == ciw_pkg::STAT_ADDR);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ciw_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrOk ? ciw_pkg::RESP_OKAY : ciw_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !awHeld_r;
    assign s_axi_wready = !wHeld_r;

    ////////////////////////////////////////////////////////////////////
    // Read channel
    wire logic [31:0] statWord = {29'h0000_0000, busOff_r, sleepAck_r, initAck_r};
    wire logic [31:0] rdMux =
        s_axi_araddr == ciw_pkg::CTRL_ADDR ? ctrl_r :
        s_axi_araddr == ciw_pkg::CFG_ADDR ? cfg_r :
        s_axi_araddr == ciw_pkg::RXFLG_ADDR ? {24'h00_0000, rxFlag_r} :
        s_axi_araddr == ciw_pkg::RXIEN_ADDR ? {24'h00_0000, rxIen_r} :
        s_axi_araddr == ciw_pkg::TXFLG_ADDR ? {29'h0000_0000, txFlag_r} :
        s_axi_araddr == ciw_pkg::TXIEN_ADDR ? {29'h0000_0000, txIen_r} :
        statWord;
    wire logic rdOk = s_axi_araddr <= ciw_pkg::STAT_ADDR && s_axi_araddr[1:0] == 2'b00;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ciw_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdOk ? rdMux : 32'h0000_0000;
            s_axi_rresp <= rdOk ? ciw_pkg::RESP_OKAY : ciw_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sleep, wake and init handshakes
    wire logic rxDom = !can_receive_line;
    // Filter trades wake latency for immunity to short dominant glitches
    wire logic activity = wake_filter_select ? (filtCnt_r == ciw_pkg::WAKE_FILTER_LEN)
                                             : rxDom;
    wire logic wakeEvt = sleepAck_r && wake_on_activity_enable && activity;
    wire logic sleepGo = sleepRq && !sleepAck_r && !evt.rxBusy && !evt.txBusy
                         && (&txFlag_r);
    wire logic [31:0] ctrlNew = merge(ctrl_r, wData_r, wStrb_r);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            filtCnt_r <= 4'h0;
        end else if (!sleepAck_r || !rxDom) begin
            filtCnt_r <= 4'h0;
        end else if (filtCnt_r != ciw_pkg::WAKE_FILTER_LEN) begin
            filtCnt_r <= filtCnt_r + 4'h1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= ciw_pkg::CTRL_RESET;
            cfg_r <= ciw_pkg::CFG_RESET;
            sleepAck_r <= 1'b0;
            initAck_r <= 1'b0;
            initCnt_r <= 3'h0;
            resync_r <= 1'b0;
            pdSleep_r <= 1'b0;
        end else begin
            if (wrCtrl) begin
                ctrl_r <= ctrlNew;
                // Requests cannot be withdrawn before acknowledged
                if (!sleepAck_r) ctrl_r[ciw_pkg::CTRL_SLEEPRQ_BIT] <= sleepRq | ctrlNew[1];
                if (!initAck_r) ctrl_r[ciw_pkg::CTRL_INIT_REQUEST_BIT] <= init_request | ctrlNew[0];
            end
            if (wrCfg && initAck_r) cfg_r <= merge(cfg_r, wData_r, wStrb_r);
            if (wakeEvt) begin
                ctrl_r[ciw_pkg::CTRL_SLEEPRQ_BIT] <= 1'b0;
                sleepAck_r <= 1'b0;
                resync_r <= 1'b1;
            end else if (sleepGo) begin
                sleepAck_r <= 1'b1;
            end else if (!sleepRq) begin
                sleepAck_r <= 1'b0;
            end
            if (resync_r && recCnt_r == ciw_pkg::RECESSIVE_RUN) resync_r <= 1'b0;
            // Latched on entry so the wake itself does not drop the permission
            pdSleep_r <= power_down && (pdSleep_r || sleepAck_r);
            if (!init_request) begin
                initCnt_r <= 3'h0;
                initAck_r <= 1'b0;
            end else if (initCnt_r != ciw_pkg::INIT_SYNC_CYCLES) begin
                initCnt_r <= initCnt_r + 3'h1;
            end else begin
                initAck_r <= !evt.rxBusy && !evt.txBusy;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bus-off recovery counting
    wire logic runDone = evt.bitTick && !rxDom && recCnt_r == ciw_pkg::RECESSIVE_RUN - 4'h1;
    wire logic countsDone = runCnt_r == ciw_pkg::RECOVERY_RUNS;
    wire logic recover = busOff_r && countsDone
                         && (!manual_recovery_bit || !busoff_hold_bit);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            recCnt_r <= 4'h0;
            runCnt_r <= 8'h00;
            busOff_r <= 1'b0;
        end else begin
            // Runs restart back to back so a long idle counts many of them
            if (evt.bitTick && rxDom) recCnt_r <= 4'h0;
            else if (evt.bitTick && recCnt_r == ciw_pkg::RECESSIVE_RUN) recCnt_r <= 4'h1;
            else if (evt.bitTick) begin
                recCnt_r <= recCnt_r + 4'h1;
            end
            if (busOff_r && runDone && !countsDone && !sleepAck_r) begin
                runCnt_r <= runCnt_r + 8'h01;
            end
            if (recover) begin
                busOff_r <= 1'b0;
                runCnt_r <= 8'h00;
            end else if (tx_state_in == ciw_pkg::ST_BUSOFF && !busOff_r) begin
                busOff_r <= 1'b1;
                runCnt_r <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flags: set wins over write-one-to-clear
    wire logic stChange = tx_state_in != tx_state_field_r || rx_state_in != rx_state_field_r;
    wire logic fullSet = !sleepAck_r && (evt.rxDone || evt.fifoNext);
    logic [7:0] rxSet, rxClr;
    assign rxSet = {wakeEvt, stChange, 4'h0, evt.overrun, fullSet};
    assign rxClr = wrRxF ? wMask[7:0] : 8'h00;
    wire logic [2:0] txSet = evt.txDone;
    wire logic [2:0] txClr = (wrTxF && !sleepAck_r) ? wMask[2:0] : 3'h0;
    wire logic [7:0] rxKeep = {1'b1, 1'b1, 4'h0, 1'b1, 1'b1};

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rxFlag_r <= 8'h00;
            rxIen_r <= 8'h00;
            txFlag_r <= ciw_pkg::TXE_RESET;
            txIen_r <= 3'h0;
            tx_state_field_r <= ciw_pkg::ST_ACTIVE;
            rx_state_field_r <= ciw_pkg::ST_ACTIVE;
        end else if (initAck_r) begin
            rxFlag_r <= 8'h00;
            txFlag_r <= ciw_pkg::TXE_RESET;
            if (wrRxE) rxIen_r <= wMask[7:0];
            if (wrTxE) txIen_r <= wMask[2:0];
        end else begin
            // Setting condition present in this cycle wins the clear
            rxFlag_r[7] <= rxSet[7] | (rxFlag_r[7] & ~rxClr[7]);
            rxFlag_r[6] <= rxSet[6] | (rxFlag_r[6] & ~rxClr[6]);
            rxFlag_r[1:0] <= rxSet[1:0] | (rxFlag_r[1:0] & ~rxClr[1:0]) & rxKeep[1:0];
            rxFlag_r[5:2] <= {rx_state_in, tx_state_in};
            txFlag_r <= txSet | (txFlag_r & ~txClr);
            tx_state_field_r <= tx_state_in;
            rx_state_field_r <= rx_state_in;
            if (wrRxE) rxIen_r <= wMask[7:0];
            if (wrTxE) txIen_r <= wMask[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt requests, registered
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= '0;
            tx_buffer_empty_flags <= ciw_pkg::TXE_RESET;
            can_active <= 1'b0;
        end else begin
            irq.wake <= rxFlag_r[7] & rxIen_r[7]
                        & (!power_down || pdSleep_r);
            irq.err <= (rxFlag_r[6] & rxIen_r[6]) | (rxFlag_r[1] & rxIen_r[1]);
            irq.rx <= rxFlag_r[0] & rxIen_r[0];
            irq.tx <= |(txFlag_r & txIen_r);
            tx_buffer_empty_flags <= txFlag_r;
            can_active <= module_enable_bit && !initAck_r && !sleepAck_r && !resync_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    property p_rx_irq; @(posedge mclk) disable iff (!reset_n)
        (rxFlag_r[0] && rxIen_r[0]) |=> irq.rx; endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");
    property p_tx_irq; @(posedge mclk) disable iff (!reset_n)
        irq.tx |-> $past(|(txFlag_r & txIen_r)); endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("tx irq spurious");
    property p_err_irq; @(posedge mclk) disable iff (!reset_n)
        irq.err |-> $past(rxFlag_r[6] | rxFlag_r[1]); endproperty
    a_err_irq: assert property (p_err_irq) else $error("err irq spurious");
    property p_set_wins; @(posedge mclk) disable iff (!reset_n)
        (evt.overrun && !initAck_r) |=> rxFlag_r[1]; endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost");
    property p_zero_keep; @(posedge mclk) disable iff (!reset_n)
        (txFlag_r[0] && !txClr[0] && !initAck_r) |=> txFlag_r[0]; endproperty
    a_zero_keep: assert property (p_zero_keep) else $error("tx lost");
    property p_wake; @(posedge mclk) disable iff (!reset_n)
        wakeEvt |=> (!sleepAck_r && rxFlag_r[7] && resync_r); endproperty
    a_wake: assert property (p_wake) else $error("wake");
    property p_noflt; @(posedge mclk) disable iff (!reset_n)
        (sleepAck_r && !wake_on_activity_enable) |=> !rxFlag_r[7] || $past(rxFlag_r[7]); endproperty
    a_noflt: assert property (p_noflt) else $error("wake without enable");
    property p_sleep; @(posedge mclk) disable iff (!reset_n)
        $rose(sleepAck_r) |-> $past(!evt.txBusy && !evt.rxBusy); endproperty
    a_sleep: assert property (p_sleep) else $error("sleep busy");
    property p_init; @(posedge mclk) disable iff (!reset_n)
        $rose(initAck_r) |-> $past(init_request, 6); endproperty
    a_init: assert property (p_init) else $error("init ack early");
    property p_rec; @(posedge mclk) disable iff (!reset_n)
        $fell(busOff_r) |-> $past(countsDone); endproperty
    a_rec: assert property (p_rec) else $error("early recovery");
    property p_man; @(posedge mclk) disable iff (!reset_n)
        $fell(busOff_r) |-> $past(!manual_recovery_bit || !busoff_hold_bit); endproperty
    a_man: assert property (p_man) else $error("hold ignored");
    c_wake: cover property (@(posedge mclk) disable iff (!reset_n) wakeEvt);
    c_rec: cover property (@(posedge mclk) disable iff (!reset_n) $fell(busOff_r));
    c_rxirq: cover property (@(posedge mclk) disable iff (!reset_n) $rose(irq.rx));
endmodule
`default_nettype wire

// ### ciw_bus_node.sv
`timescale 1ns/1ns
`default_nettype none
// Far-side node: recessive idle, dominant bursts on command
module ciw_bus_node (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] domLen,
    input wire logic domGo,
    output logic canRx,
    output logic bitTick
);
    logic [7:0] domCnt_r;
    logic tick_r;
    // Two clocks per bit keeps the long recovery count short
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            domCnt_r <= 8'h00;
            tick_r <= 1'h0;
        end else begin
            tick_r <= ~tick_r;
            if (domGo)
                domCnt_r <= domLen;
            else if (domCnt_r != 8'h00)
                domCnt_r <= domCnt_r - 8'h01;
        end
    end
    assign bitTick = tick_r;
    assign canRx = (domCnt_r == 8'h00);
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic mclk = 1'h0;
    logic reset_n = 1'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0, domLen = 8'h8;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, canRx, bitTick, canActive;
    logic [1:0] bresp, rresp, txState = 2'h0, rxState = 2'h0;
    logic rxDone = 1'h0, fifoNext = 1'h0, overrun = 1'h0, txBusy = 1'h0, rxBusy = 1'h0;
    logic powerDown = 1'h0, domGo = 1'h0;
    logic [2:0] txDone = 3'h0, txEmpty;
    ciw_pkg::ciw_evt_t evt;
    ciw_pkg::ciw_irq_t irq;
    int miscompares = 0, n_checks = 0;
    assign evt = {rxDone, fifoNext, overrun, txDone, txBusy, rxBusy, bitTick};
    always #50 mclk = ~mclk;
    ciw_core u_ciw_core (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .can_receive_line(canRx), .evt(evt),
        .tx_state_in(txState), .rx_state_in(rxState), .power_down(powerDown),
        .irq(irq), .tx_buffer_empty_flags(txEmpty), .can_active(canActive));
    ciw_bus_node u_ciw_bus_node (.mclk(mclk), .reset_n(reset_n), .domLen(domLen),
        .domGo(domGo), .canRx(canRx), .bitTick(bitTick));
    ////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stall(input string nm);
        miscompares++;
        $display("FAIL %s expected answer seen timeout", nm);
        give_verdict();
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask
    // Handshakes are judged at the falling edge, where nothing moves
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic hAw, hW, hB;
        logic [1:0] r;
        @(posedge mclk);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= d;
        wvalid <= 1'h1;
        bready <= 1'h1;
        hB = 1'h0;
        for (int n = 0; n < 100 && !hB; n++) begin
            @(negedge mclk);
            hAw = awvalid && awready;
            hW = wvalid && wready;
            hB = bvalid && bready;
            r = bresp;
            @(posedge mclk);
            if (hAw) awvalid <= 1'h0;
            if (hW) wvalid <= 1'h0;
            if (hB) bready <= 1'h0;
        end
        if (!hB) stall("write");
        chk("bresp", {30'h0, ciw_pkg::RESP_OKAY}, {30'h0, r});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic hAr, hR;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        hR = 1'h0;
        for (int n = 0; n < 100 && !hR; n++) begin
            @(negedge mclk);
            hAr = arvalid && arready;
            hR = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge mclk);
            if (hAr) arvalid <= 1'h0;
            if (hR) rready <= 1'h0;
        end
        if (!hR) stall("read");
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(nm, e, d);
    endtask
    task automatic wait_stat(input int b, input logic v);
        logic [31:0] d;
        logic [1:0] r;
        for (int n = 0; n < 100; n++) begin
            rd(ciw_pkg::STAT_ADDR, d, r);
            if (d[b] === v) return;
        end
        stall("status");
    endtask
    // Flag word: {wake, status change, rx state, tx state, overrun, full}
    function automatic logic [31:0] expRx(input logic [3:0] fl);
        return {24'h0, fl[3], fl[2], rxState, txState, fl[1], fl[0]};
    endfunction
    function automatic logic [31:0] expOr(input logic [31:0] fl, input logic [31:0] en);
        return {31'h0, |(fl & en)};
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d, en;
        logic [1:0] r;
        logic [2:0] m;
        void'($urandom(79666));
        cyc(2);
        reset_n <= 1'h1;
        rdchk("ctrl", ciw_pkg::CTRL_ADDR, ciw_pkg::CTRL_RESET);
        rdchk("cfg", ciw_pkg::CFG_ADDR, ciw_pkg::CFG_RESET);
        rdchk("txflg", ciw_pkg::TXFLG_ADDR, {29'h0, ciw_pkg::TXE_RESET});
        rd(8'h40, d, r);
        chk("unmapped rresp", {30'h0, ciw_pkg::RESP_SLVERR}, {30'h0, r});
        chk("unmapped rdata", 32'h0, d);
        wait_stat(ciw_pkg::ST_INIT_ACKNOWLEDGE_BIT, 1'h1);
        wr(ciw_pkg::CFG_ADDR, 32'h1);
        wr(ciw_pkg::CTRL_ADDR, 32'h0);
        wait_stat(ciw_pkg::ST_INIT_ACKNOWLEDGE_BIT, 1'h0);
        wr(ciw_pkg::CFG_ADDR, 32'h6);
        rdchk("cfg locked", ciw_pkg::CFG_ADDR, 32'h1);
        @(posedge mclk);
        rxDone <= 1'h1;
        overrun <= 1'h1;
        txState <= 2'h2;
        rxState <= 2'h1;
        @(posedge mclk);
        rxDone <= 1'h0;
        overrun <= 1'h0;
        rdchk("rxflg", ciw_pkg::RXFLG_ADDR, expRx(4'h7));
        for (int i = 0; i < 6; i++) begin
            en = $urandom() & 32'h43;
            wr(ciw_pkg::RXIEN_ADDR, en);
            cyc(2);
            chk("irq rx", expOr(32'h1, en), {31'h0, irq.rx});
            chk("irq err", expOr(32'h42, en), {31'h0, irq.err});
        end
        wr(ciw_pkg::RXIEN_ADDR, 32'h43);
        wr(ciw_pkg::RXFLG_ADDR, 32'h0);
        wr(ciw_pkg::RXFLG_ADDR, 32'h42);
        rdchk("rx w1c", ciw_pkg::RXFLG_ADDR, expRx(4'h1));
        chk("irq err off", 32'h0, {31'h0, irq.err});
        wr(ciw_pkg::RXFLG_ADDR, 32'h1);
        cyc(2);
        chk("irq rx off", 32'h0, {31'h0, irq.rx});
        @(posedge mclk);
        fifoNext <= 1'h1;
        @(posedge mclk);
        fifoNext <= 1'h0;
        rdchk("rx next", ciw_pkg::RXFLG_ADDR, expRx(4'h1));
        chk("irq rx next", 32'h1, {31'h0, irq.rx});
        wr(ciw_pkg::RXFLG_ADDR, 32'h1);
        for (int i = 0; i < 4; i++) begin
            m = 3'($urandom());
            en = $urandom() & 32'h7;
            wr(ciw_pkg::TXIEN_ADDR, en);
            wr(ciw_pkg::TXFLG_ADDR, {29'h0, m});
            cyc(2);
            chk("tx empty", {29'h0, ~m}, {29'h0, txEmpty});
            chk("irq tx", expOr({29'h0, ~m}, en), {31'h0, irq.tx});
            @(posedge mclk);
            txDone <= m;
            @(posedge mclk);
            txDone <= 3'h0;
            cyc(2);
            chk("tx refill", 32'h7, {29'h0, txEmpty});
        end
        wr(ciw_pkg::RXIEN_ADDR, 32'h80);
        wr(ciw_pkg::CTRL_ADDR, 32'h6);
        wait_stat(ciw_pkg::ST_SLEEPAK_BIT, 1'h1);
        chk("irq wake idle", 32'h0, {31'h0, irq.wake});
        @(posedge mclk);
        powerDown <= 1'h1;
        domGo <= 1'h1;
        @(posedge mclk);
        domGo <= 1'h0;
        cyc(12);
        chk("irq wake", 32'h1, {31'h0, irq.wake});
        powerDown <= 1'h0;
        wr(ciw_pkg::CTRL_ADDR, 32'h0);
        wr(ciw_pkg::RXFLG_ADDR, 32'h80);
        // Bus-off needs 128 runs of 11 recessive bits, two clocks each
        txState <= 2'h3;
        cyc(3);
        txState <= 2'h0;
        wait_stat(ciw_pkg::ST_BUSOFF_BIT, 1'h1);
        cyc(2600);
        rdchk("busoff held", ciw_pkg::STAT_ADDR, 32'h4);
        wait_stat(ciw_pkg::ST_BUSOFF_BIT, 1'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
